// File: src/io_port_decode.sv
// io cycle decoder for ide, keyboard and video ports
`timescale 1ns/1ps
module io_port_decode (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        io_cycle_valid,
  input  wire logic [15:0] io_addr,
  input  wire logic        legacy_decode,
  input  wire logic        ide_ctrl_enable,
  input  wire logic        ide_pri_notify,
  input  wire logic        ide_sec_notify,
  output logic             pri_hit,
  output logic             sec_hit,
  output logic             keyboard_hit,
  output logic             video_hit
);
  import wake_pkg::*;

  logic pri_legacy;
  logic sec_legacy;
  logic kbd_port;
  logic video_port;

  assign pri_legacy = io_cycle_valid &&
                      (((io_addr >= PRI_FIRST) && (io_addr <= PRI_LAST)) || (io_addr == PRI_ALT));
  assign sec_legacy = io_cycle_valid &&
                      (((io_addr >= SEC_FIRST) && (io_addr <= SEC_LAST)) || (io_addr == SEC_ALT));
  assign kbd_port   = io_cycle_valid && ((io_addr == KBD_DATA) || (io_addr == KBD_CMD));
  assign video_port = io_cycle_valid && (io_addr >= VIDEO_FIRST) && (io_addr <= VIDEO_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_hit <= 1'b0;
      sec_hit <= 1'b0;
    end else if (legacy_decode) begin
      pri_hit <= pri_legacy;
      sec_hit <= sec_legacy;
    end else begin
      pri_hit <= ide_ctrl_enable & ide_pri_notify;
      sec_hit <= ide_ctrl_enable & ide_sec_notify;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keyboard_hit <= 1'b0;
      video_hit    <= 1'b0;
    end else begin
      keyboard_hit <= kbd_port;
      video_hit    <= video_port;
    end
  end
endmodule

// File: src/standby_wake_smi_logic.sv
// standby wake smi logic with ahb-lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module standby_wake_smi_logic (
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // power state and events
  input  wire logic        standby_active,
  input  wire logic        io_cycle_valid,
  input  wire logic [15:0] io_addr,
  input  wire logic        ide_pri_notify,
  input  wire logic        ide_sec_notify,
  input  wire logic        modem_ring,
  input  wire logic        bus_hold_request_n,
  input  wire logic        pci_request_n,
  input  wire logic        usb_activity,
  input  wire logic        usb_bus_busy,
  input  wire logic        usb_service_req,
  input  wire logic        display_monitor_event,
  input  wire logic        standby_monitor_event,
  input  wire logic        extra_wake_event,
  input  wire logic        serial_irq_access,
  input  wire logic        smbus_event,
  input  wire logic        io_group_c_access,
  input  wire logic        parallel_access,
  input  wire logic        serial_port_access,
  input  wire logic        floppy_access,
  input  wire logic        audio_access,
  output logic             smi
);
  import wake_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [WAKE_W-1:0] enable_reg;
  logic [WAKE_W-1:0] mask_reg;
  logic [EXT_W-1:0]  ext_reg;
  logic              smi_reg;
  logic              smi_next;
  logic [31:0]       hrdata_reg;
  logic [31:0]       hrdata_next;

  logic              dp_write_reg;
  logic              rd_pend_reg;
  logic [IDX_W-1:0]  dp_idx_reg;
  logic              accept;

  logic              wr_ctrl;
  logic              wr_mask;
  logic              wr_enable;
  logic              wr_status;
  logic              wr_ext;

  logic              pri_hit;
  logic              sec_hit;
  logic              keyboard_hit;
  logic              video_hit;
  logic              bus_master_req;

  logic [WAKE_W-1:0] wake_set;
  logic [WAKE_W-1:0] status;

  wake_flags_if flags_bus ();

  // ahb address phase accept
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_write_reg <= 1'b0;
      rd_pend_reg  <= 1'b0;
      dp_idx_reg   <= '0;
    end else if (hreadyout) begin
      dp_write_reg <= accept && hwrite;
      rd_pend_reg  <= accept && !hwrite;
      if (accept) begin
        dp_idx_reg <= haddr[IDX_MSB:IDX_LSB];
      end
    end else begin
      rd_pend_reg <= 1'b0;
    end
  end

  // one wait state on reads, none on writes
  assign hreadyout = !rd_pend_reg;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  // write strobes in the data phase
  assign wr_ctrl   = dp_write_reg && (dp_idx_reg == IDX_CTRL);
  assign wr_mask   = dp_write_reg && (dp_idx_reg == IDX_SMI_MASK);
  assign wr_enable = dp_write_reg && (dp_idx_reg == IDX_WAKE_EN);
  assign wr_status = dp_write_reg && (dp_idx_reg == IDX_WAKE_STAT);
  assign wr_ext    = dp_write_reg && (dp_idx_reg == IDX_EXT_SW_EN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata[CTRL_W-1:0] & CTRL_USED;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= hwdata[WAKE_W-1:0] & ENABLE_USED;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= hwdata[WAKE_W-1:0] & STATUS_USED;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_reg <= EXT_RESET;
    end else if (wr_ext) begin
      ext_reg <= hwdata[EXT_W-1:0];
    end
  end

  // read mux, unmapped and reserved read zero
  always_comb begin
    hrdata_next = '0;
    case (dp_idx_reg)
      IDX_CTRL:      hrdata_next[CTRL_W-1:0] = ctrl_reg;
      IDX_SMI_MASK:  hrdata_next[WAKE_W-1:0] = mask_reg;
      IDX_WAKE_EN:   hrdata_next[WAKE_W-1:0] = enable_reg;
      IDX_RSVD_A:    hrdata_next[RSVD_W-1:0] = RSVD_VALUE;
      IDX_WAKE_STAT: hrdata_next[WAKE_W-1:0] = status & STATUS_USED;
      IDX_RSVD_B:    hrdata_next[RSVD_W-1:0] = RSVD_VALUE;
      IDX_EXT_SW_EN: hrdata_next[EXT_W-1:0]  = ext_reg;
      default:       hrdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= '0;
    end else if (rd_pend_reg) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // io cycle decode
  io_port_decode u_decode (
    .clk             (clk),
    .rst             (rst),
    .io_cycle_valid  (io_cycle_valid),
    .io_addr         (io_addr),
    .legacy_decode   (ctrl_reg[CTRL_LEGACY_IDE_BIT]),
    .ide_ctrl_enable (ctrl_reg[CTRL_IDE_CTRL_EN_BIT]),
    .ide_pri_notify  (ide_pri_notify),
    .ide_sec_notify  (ide_sec_notify),
    .pri_hit         (pri_hit),
    .sec_hit         (sec_hit),
    .keyboard_hit    (keyboard_hit),
    .video_hit       (video_hit)
  );

  assign bus_master_req = !bus_hold_request_n || !pci_request_n;

  // event to status bit mapping
  always_comb begin
    wake_set = '0;
    if (standby_active) begin
      wake_set[BIT_STANDBY_TO_ON] = enable_reg[BIT_STANDBY_TO_ON] &&
                                    (standby_monitor_event || extra_wake_event);
      wake_set[BIT_DISPLAY]       = enable_reg[BIT_DISPLAY] && display_monitor_event;
      wake_set[BIT_USB_ACCESS]    = enable_reg[BIT_USB_ACCESS] && usb_activity;
      wake_set[BIT_BUS_MASTER]    = enable_reg[BIT_BUS_MASTER] && bus_master_req;
      wake_set[BIT_MODEM_RING]    = enable_reg[BIT_MODEM_RING] && modem_ring;
      wake_set[BIT_IDE_PRIMARY]   = enable_reg[BIT_IDE_PRIMARY] && pri_hit;
      wake_set[BIT_IDE_SECONDARY] = enable_reg[BIT_IDE_SECONDARY] && sec_hit;
      wake_set[BIT_AUDIO]         = enable_reg[BIT_AUDIO] && audio_access;
      wake_set[BIT_VIDEO]         = enable_reg[BIT_VIDEO] && video_hit;
      wake_set[BIT_FLOPPY]        = enable_reg[BIT_FLOPPY] && floppy_access;
      wake_set[BIT_SERIAL]        = enable_reg[BIT_SERIAL] && serial_port_access;
      wake_set[BIT_KEYBOARD]      = enable_reg[BIT_KEYBOARD] && keyboard_hit;
      wake_set[BIT_PARALLEL]      = enable_reg[BIT_PARALLEL] && parallel_access;
      wake_set[BIT_IO_GROUP_C]    = enable_reg[BIT_IO_GROUP_C] && io_group_c_access;
      wake_set[BIT_SMBUS]         = enable_reg[BIT_SMBUS] && smbus_event;
      wake_set[BIT_SERIAL_IRQ]    = enable_reg[BIT_SERIAL_IRQ] && serial_irq_access;
    end
    if (usb_bus_busy) begin
      wake_set[BIT_USB_ACCESS] = 1'b1;
    end
    wake_set[BIT_USB_SERVICE] = usb_service_req;
  end

  assign flags_bus.set   = wake_set & STATUS_USED;
  assign flags_bus.clear = wr_status ? hwdata[WAKE_W-1:0] : '0;
  assign status          = flags_bus.flags;

  sticky_flags #(
    .USED      (STATUS_USED),
    .RESET_VAL (STATUS_RESET)
  ) u_status (
    .clk (clk),
    .rst (rst),
    .f   (flags_bus.owner)
  );

  // smi while an unmasked status bit is set that is enabled, or is the usb service bit, which needs no enable
  assign smi_next = |(status & mask_reg & (enable_reg | SMI_FORCED));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_reg <= 1'b0;
    end else begin
      smi_reg <= smi_next;
    end
  end

  assign smi = smi_reg;

  // hsize is accepted for any value; only whole words are expected
  logic unused_inputs;
  assign unused_inputs = ^{hsize, haddr[31:IDX_MSB+1], haddr[IDX_LSB-1:0], hwdata[31:WAKE_W]};
endmodule

// File: src/sticky_flags.sv
// sticky write-one-to-clear status flags
`timescale 1ns/1ps
module sticky_flags #(
  parameter logic [wake_pkg::WAKE_W-1:0] USED      = wake_pkg::STATUS_USED,
  parameter logic [wake_pkg::WAKE_W-1:0] RESET_VAL = wake_pkg::STATUS_RESET
) (
  input wire logic    clk,
  input wire logic    rst,
  wake_flags_if.owner f
);
  import wake_pkg::*;

  logic [WAKE_W-1:0] flags_reg;

  // set wins over clear; flag holds until cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= RESET_VAL;
    end else begin
      flags_reg <= ((flags_reg & ~f.clear) | f.set) & USED;
    end
  end

  assign f.flags = flags_reg;
endmodule

// File: src/wake_flags_if.sv
// carrier between the top and the sticky status flags
`timescale 1ns/1ps
interface wake_flags_if;
  import wake_pkg::*;
  logic [WAKE_W-1:0] set;
  logic [WAKE_W-1:0] clear;
  logic [WAKE_W-1:0] flags;
  modport owner (input set, input clear, output flags);
  modport user  (output set, output clear, input flags);
endinterface

// File: src/wake_pkg.sv
// constants for the standby wake smi logic
package wake_pkg;

  localparam int WAKE_W = 24;
  localparam int EXT_W  = 16;
  localparam int CTRL_W = 8;
  localparam int RSVD_W = 8;
  localparam int IDX_W  = 10;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 11;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h040;
  localparam logic [IDX_W-1:0] IDX_SMI_MASK   = 10'h041;
  localparam logic [IDX_W-1:0] IDX_WAKE_EN    = 10'h044;
  localparam logic [IDX_W-1:0] IDX_RSVD_A     = 10'h047;
  localparam logic [IDX_W-1:0] IDX_WAKE_STAT  = 10'h048;
  localparam logic [IDX_W-1:0] IDX_RSVD_B     = 10'h04B;
  localparam logic [IDX_W-1:0] IDX_EXT_SW_EN  = 10'h04C;

  // wake status / enable bit positions
  localparam int BIT_STANDBY_TO_ON = 0;
  localparam int BIT_DISPLAY       = 1;
  localparam int BIT_USB_ACCESS    = 2;
  localparam int BIT_BUS_MASTER    = 3;
  localparam int BIT_MODEM_RING    = 4;
  localparam int BIT_IDE_PRIMARY   = 5;
  localparam int BIT_IDE_SECONDARY = 6;
  localparam int BIT_AUDIO         = 7;
  localparam int BIT_VIDEO         = 8;
  localparam int BIT_FLOPPY        = 9;
  localparam int BIT_SERIAL        = 10;
  localparam int BIT_KEYBOARD      = 11;
  localparam int BIT_PARALLEL      = 12;
  localparam int BIT_IO_GROUP_C    = 15;
  localparam int BIT_SMBUS         = 19;
  localparam int BIT_SERIAL_IRQ    = 20;
  localparam int BIT_USB_SERVICE   = 21;

  localparam logic [WAKE_W-1:0] STATUS_USED  = 24'h389FFF;
  localparam logic [WAKE_W-1:0] ENABLE_USED  = 24'h189FFF;
  localparam logic [WAKE_W-1:0] SMI_FORCED   = 24'h200000;
  localparam logic [WAKE_W-1:0] STATUS_RESET = 24'h000000;
  localparam logic [WAKE_W-1:0] ENABLE_RESET = 24'h000000;
  localparam logic [WAKE_W-1:0] MASK_RESET   = 24'h389FFF;
  localparam logic [EXT_W-1:0]  EXT_RESET    = 16'h0000;
  localparam logic [RSVD_W-1:0] RSVD_VALUE   = 8'h00;

  // control register fields
  localparam int CTRL_IDE_CTRL_EN_BIT = 0;
  localparam int CTRL_LEGACY_IDE_BIT  = 7;
  localparam logic [CTRL_W-1:0] CTRL_USED  = 8'h81;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // io port decode ranges
  localparam logic [15:0] PRI_FIRST   = 16'h01F0;
  localparam logic [15:0] PRI_LAST    = 16'h01F7;
  localparam logic [15:0] PRI_ALT     = 16'h03F6;
  localparam logic [15:0] SEC_FIRST   = 16'h0170;
  localparam logic [15:0] SEC_LAST    = 16'h0177;
  localparam logic [15:0] SEC_ALT     = 16'h0376;
  localparam logic [15:0] KBD_DATA    = 16'h0060;
  localparam logic [15:0] KBD_CMD     = 16'h0064;
  localparam logic [15:0] VIDEO_FIRST = 16'h03B0;
  localparam logic [15:0] VIDEO_LAST  = 16'h03DF;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// File: tb/smi_host_model.sv
// processor side model that counts smi requests
`timescale 1ns/1ps
module smi_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       smi,
  output logic      [7:0] smi_requests
);
  logic smi_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_reg      <= 1'b0;
      smi_requests <= 8'h00;
    end else begin
      smi_reg <= smi;
      if (smi && !smi_reg) smi_requests <= smi_requests + 8'h01;
    end
  end
endmodule

// File: tb/standby_wake_smi_logic_asserts.sv
// assertion checker for the standby wake smi logic ports
`timescale 1ns/1ps
module standby_wake_smi_logic_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        usb_service_req,
  input wire logic        smi
);
  import wake_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic taken;
  logic wr_taken;
  assign taken    = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_taken = taken && hwrite;

  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  write_ready_a: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  wait_single_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  resp_okay_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  reset_quiet_a: assert property ($fell(rst) |-> !smi && hreadyout)
    else $error("outputs not idle after reset");
  service_smi_a: assert property (usb_service_req |-> ##2 smi)
    else $error("usb service request gave no smi");
  smi_sticky_a: assert property (smi && !$past(wr_taken, 2) |=> smi)
    else $error("smi dropped without a register write");

  read_seen_c: cover property (taken && !hwrite ##2 hreadyout);
  write_seen_c: cover property (wr_taken);
  smi_rise_c: cover property ($rose(smi));
endmodule

bind standby_wake_smi_logic standby_wake_smi_logic_asserts standby_wake_smi_logic_asserts_i (
  .clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .usb_service_req, .smi);

// File: tb/standby_wake_smi_logic_tb.sv
// self-checking testbench for the standby wake smi logic
`timescale 1ns/1ps
module standby_wake_smi_logic_tb;
  import wake_pkg::*;
  localparam int SB[15] = '{0, 0, 1, 2, 3, 3, 4, 7, 9, 10, 12, 15, 19, 20, 21};
  localparam logic [15:0] IOA[12] = '{16'h01F0, 16'h01F7, 16'h03F6, 16'h0170, 16'h0177,
    16'h0376, 16'h0060, 16'h0064, 16'h03B0, 16'h03DF, 16'h01EF, 16'h01F8};
  localparam int IOB[12] = '{5, 5, 5, 6, 6, 6, 11, 11, 8, 8, 32, 32};
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic        hsel           = 1'b0;
  logic [31:0] haddr          = 32'h00000000;
  logic [1:0]  htrans         = 2'h0;
  logic        hwrite         = 1'b0;
  logic [31:0] hwdata         = 32'h00000000;
  logic        standby_active = 1'b0;
  logic        io_cycle_valid = 1'b0;
  logic [15:0] io_addr        = 16'h0000;
  logic [17:0] ev             = 18'h00000;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        smi;
  logic [7:0]  smi_requests;
  logic [31:0] seen;
  logic [7:0]  rises          = 8'h00;
  int          err_total      = 0;
  int          total_checks   = 0;

  always #25 clk = ~clk;

  standby_wake_smi_logic standby_wake_smi_logic_i (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
    .hreadyout, .hresp, .hrdata, .standby_active, .io_cycle_valid, .io_addr,
    .ide_pri_notify(ev[16]), .ide_sec_notify(ev[17]), .modem_ring(ev[6]),
    .bus_hold_request_n(~ev[4]), .pci_request_n(~ev[5]), .usb_activity(ev[3]),
    .usb_bus_busy(ev[15]), .usb_service_req(ev[14]), .display_monitor_event(ev[2]),
    .standby_monitor_event(ev[0]), .extra_wake_event(ev[1]), .serial_irq_access(ev[13]),
    .smbus_event(ev[12]), .io_group_c_access(ev[11]), .parallel_access(ev[10]),
    .serial_port_access(ev[9]), .floppy_access(ev[8]), .audio_access(ev[7]), .smi);

  smi_host_model smi_host_model_i (.clk, .rst, .smi, .smi_requests);

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_ready();
    do @(negedge clk); while (hreadyout !== 1'b1);
    seen = hrdata;
    @(posedge clk);
  endtask

  task automatic access(input logic [9:0] idx, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {20'h00000, idx, 2'h0};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
    access(idx, 1'b0, 32'h00000000);
    chk(name, exp, seen);
  endtask

  task automatic probe(input int k, input logic [15:0] a, input logic [31:0] exp, input logic s);
    @(posedge clk);
    if (k < 18) ev[k] <= 1'b1;
    else begin
      io_addr        <= a;
      io_cycle_valid <= 1'b1;
    end
    repeat (2) @(posedge clk);
    ev             <= 18'h00000;
    io_cycle_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("smi", {31'h0, s}, {31'h0, smi});
    rchk("status", IDX_WAKE_STAT, exp);
    access(IDX_WAKE_STAT, 1'b1, 32'hFFFFFFFF);
    repeat (2) @(posedge clk);
    chk("smi_clear", 32'h0, {31'h0, smi});
    rchk("status_clear", IDX_WAKE_STAT, 32'h0);
    if (s) rises++;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk("status", IDX_WAKE_STAT, 32'h0);
    rchk("ext_enable", IDX_EXT_SW_EN, 32'h0);
    rchk("reserved_a", IDX_RSVD_A, 32'h0);
    rchk("ctrl", IDX_CTRL, 32'h0);
    rchk("mask", IDX_SMI_MASK, {8'h00, MASK_RESET});
    access(IDX_EXT_SW_EN, 1'b1, 32'hFFFFA5A5);
    rchk("ext_enable", IDX_EXT_SW_EN, 32'h0000A5A5);
    access(IDX_RSVD_B, 1'b1, 32'hFFFFFFFF);
    rchk("reserved_b", IDX_RSVD_B, 32'h0);
    access(10'h3FF, 1'b1, 32'hFFFFFFFF);
    rchk("unmapped", 10'h3FF, 32'h0);
    $display("test registers done");
    access(IDX_WAKE_EN, 1'b1, 32'hFFFFFFFF);
    rchk("enable", IDX_WAKE_EN, 32'h00189FFF);
    access(IDX_CTRL, 1'b1, 32'hFFFFFFFF);
    rchk("ctrl", IDX_CTRL, {24'h000000, CTRL_USED});
    access(IDX_CTRL, 1'b1, 32'h00000080);
    rchk("ctrl", IDX_CTRL, 32'h00000080);
    standby_active <= 1'b1;
    for (int k = 0; k < 15; k++) begin
      probe(k, 16'h0, 32'h1 << SB[k], 1'b1);
    end
    for (int i = 0; i < 12; i++) begin
      probe(18, IOA[i], 32'h1 << IOB[i], IOB[i] < 32);
    end
    access(IDX_CTRL, 1'b1, 32'h00000001);
    probe(16, 16'h0, 32'h00000020, 1'b1);
    probe(17, 16'h0, 32'h00000040, 1'b1);
    probe(18, 16'h01F0, 32'h0, 1'b0);
    access(IDX_CTRL, 1'b1, 32'h0);
    probe(17, 16'h0, 32'h0, 1'b0);
    $display("test events done");
    standby_active <= 1'b0;
    probe(6, 16'h0, 32'h0, 1'b0);
    probe(15, 16'h0, 32'h00000004, 1'b1);
    access(IDX_WAKE_EN, 1'b1, 32'h0);
    probe(14, 16'h0, 32'h00200000, 1'b1);
    probe(15, 16'h0, 32'h00000004, 1'b0);
    standby_active <= 1'b1;
    probe(6, 16'h0, 32'h0, 1'b0);
    access(IDX_WAKE_EN, 1'b1, 32'hFFFFFFFF);
    access(IDX_SMI_MASK, 1'b1, 32'h00389FEF);
    rchk("mask", IDX_SMI_MASK, 32'h00389FEF);
    probe(6, 16'h0, 32'h00000010, 1'b0);
    $display("test gating done");
    chk("smi_requests", {24'h0, rises}, {24'h0, smi_requests});
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
